// ---- inc/mcp_pkg.sv ----
package mcp_pkg;
   // register indices on the plain register port
   localparam logic [3:0] A_CHAN = 4'h0;
   localparam logic [3:0] A_MODE = 4'h1;
   localparam logic [3:0] A_DEV  = 4'h2;
   localparam logic [3:0] A_PCM  = 4'h3;
   localparam logic [3:0] A_DUMP = 4'h4;
   localparam logic [3:0] A_DSEL = 4'h5;
   localparam logic [3:0] A_MEM  = 4'h6;
   // field positions
   localparam int M_OMNI  = 0;
   localparam int M_LOCAL = 1;
   localparam int M_NF    = 2;
   localparam int M_PROT  = 4;
   localparam int M_MULTI = 5;
   localparam int C_RX    = 4;
   localparam int DV_MODE = 4;
   localparam int DS_BANK = 4;
   // reset values
   localparam logic [7:0] RST_CHAN = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h02;
   localparam logic [7:0] RST_DEV  = 8'h10;
   localparam logic [1:0] RST_PCM  = 2'h1;
   // setting encodings
   localparam logic [1:0] PC_OFF = 2'h0;
   localparam logic [1:0] PC_NORMAL = 2'h1;
   localparam logic [1:0] PC_DIRECT = 2'h2;
   localparam logic [1:0] NF_ALL = 2'h0;
   localparam logic [1:0] NF_ODD = 2'h1;
   localparam logic [1:0] NF_EVEN = 2'h2;
   localparam logic [1:0] DV_OFF = 2'h0;
   localparam logic [1:0] DV_NUM = 2'h1;
   localparam logic [1:0] DV_ALL = 2'h2;
   // status nibbles
   localparam logic [3:0] ST_NOTE_OFF = 4'h8;
   localparam logic [3:0] ST_NOTE_ON  = 4'h9;
   localparam logic [3:0] ST_PC       = 4'hC;
   // program numbers and memory codes
   localparam logic [6:0] NUM_MULTI_LO = 7'h40;
   localparam logic [6:0] NUM_MULTI_HI = 7'h4F;
   localparam logic [6:0] MC_VOICE_LO  = 7'h75;
   localparam logic [6:0] MC_MI_INT    = 7'h77;
   localparam logic [6:0] MC_MI_CARD   = 7'h78;
   localparam logic [6:0] MC_MULTI_LO  = 7'h7D;
   // dump kinds
   localparam logic [3:0] DUMP_MIN    = 4'h1;
   localparam logic [3:0] DUMP_MAX    = 4'hC;
   localparam logic [3:0] DUMP_1MULTI = 4'h8;

   typedef enum logic [2:0] {
      MCP_D_IDLE = 3'b001,
      MCP_D_BUSY = 3'b010,
      MCP_D_DONE = 3'b100
   } mcp_dst_t;

   typedef struct packed {
      logic       vld;
      logic [7:0] stat;
      logic [6:0] d1;
      logic [6:0] d2;
   } mcp_msg_t;

   typedef struct packed {
      logic       vld;
      logic [3:0] dev;
      logic       bulk;
      logic       single;
   } mcp_sx_t;

   typedef struct packed {
      logic       vld;
      logic       multi;
      logic [3:0] part;
      logic [6:0] mem;
      logic [5:0] num;
   } mcp_sel_t;

   typedef struct packed {
      logic       start;
      logic [3:0] kind;
      logic [1:0] bank;
      logic [3:0] num;
      logic [3:0] dev;
   } mcp_dump_t;
endpackage

// ---- core/mcp_filter.sv ----
// Functional notes
// - keyboard data sent on transmit channel
// - voice mode: receive channel or omni only
// - local off keeps keyboard from tones
// - odd/even filter on received notes only
// - sysex needs device number, off, all
// - bulk protect blocks memory writes
// - program change off: none in, none out except a held direct number
// - normal voice: 0-63 select, rest ignored
// - normal multi: parts, 64-79 select multis
// - transmit 0-63 voices, 64-79 multis
// - direct handles 0-116 as normal
// - direct: memory code precedes selection
// - 117-124 voice, 125-127 multi memory
// - memory code table 117 to 127
// - codes 119 and 120 treated alike
// - twelve dump kinds, 01 to 12
// - dump busy then done indication
// - single voice by bank and number
// - single multi only from internal
// - dump carries our device number
// - single dumps land in edit buffer
module mcp_filter
   import mcp_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic [3:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic [7:0]             reg_rdata_o,
   input  wire mcp_pkg::mcp_msg_t rx_i,
   input  wire mcp_pkg::mcp_msg_t kbd_i,
   input  wire mcp_pkg::mcp_sel_t sel_i,
   input  wire mcp_pkg::mcp_sx_t  sx_i,
   input  wire logic              store_i,
   input  wire logic              dump_end_i,
   output mcp_pkg::mcp_msg_t      tg_rx_o,
   output mcp_pkg::mcp_msg_t      tg_kbd_o,
   output mcp_pkg::mcp_msg_t      tx_o,
   output mcp_pkg::mcp_msg_t      pc_tx_o,
   output mcp_pkg::mcp_sel_t      sel_o,
   output mcp_pkg::mcp_dump_t     dump_o,
   output logic                   sx_ok_o,
   output logic                   mem_we_o,
   output logic                   edit_we_o,
   output logic                   edit_drop_o
);
   import mcp_pkg::*;

   typedef struct packed {
      logic [7:0] chan;
      logic [7:0] mode;
      logic [7:0] dev;
      logic [1:0] pcm;
      logic [7:0] dsel;
      mcp_dst_t   dst;
      logic [3:0] dkind;
      logic [6:0] pend;
      logic [6:0] txlast;
      logic       txhold;
      logic [6:0] txnum;
      logic [6:0] cur_mem;
      logic       edit_full;
      logic [7:0] rdata;
      mcp_msg_t   tg_rx;
      mcp_msg_t   tg_kbd;
      mcp_msg_t   tx;
      mcp_msg_t   pc_tx;
      mcp_sel_t   sel;
      mcp_dump_t  dump;
      logic       sx_ok;
      logic       mem_we;
      logic       edit_we;
      logic       edit_drop;
   } mcp_st_t;

   mcp_st_t st;
   mcp_st_t next_st;

   function automatic logic is_chan(input logic [7:0] s);
      return s[7] && (s[7:4] != 4'hF);
   endfunction

   function automatic mcp_msg_t rechan(input mcp_msg_t m, input logic [3:0] c);
      mcp_msg_t r;
      r = m;
      r.stat[3:0] = c;
      return r;
   endfunction

   logic [3:0] rch;
   logic       hit;
   logic       acc;
   logic       is_note;
   logic       nf_pass;
   logic       is_pc;
   logic [6:0] tx_num;
   logic       mem_chg;

   // receive qualification, shared with the checks below
   always_comb begin
      rch = rx_i.stat[3:0];
      hit = st.mode[M_OMNI] || (rch == st.chan[C_RX+:4]);
      acc = rx_i.vld && is_chan(rx_i.stat) && (st.mode[M_MULTI] || hit);
      is_note = (rx_i.stat[7:4] == ST_NOTE_ON) || (rx_i.stat[7:4] == ST_NOTE_OFF);
      nf_pass = (st.mode[M_NF+:2] == NF_ALL) || ((st.mode[M_NF+:2] == NF_ODD) && rx_i.d1[0])
                || ((st.mode[M_NF+:2] == NF_EVEN) && !rx_i.d1[0]);
      is_pc = rx_i.stat[7:4] == ST_PC;
      // multi numbers sit above the voices
      tx_num = sel_i.multi ? (NUM_MULTI_LO | {3'h0, sel_i.num[3:0]}) : {1'b0, sel_i.num};
      mem_chg = sel_i.vld && (sel_i.mem != st.cur_mem);
   end

   // whole next state; pulses default low every cycle
   always_comb begin
      next_st = st;
      next_st.rdata = 8'h00;
      next_st.tg_rx.vld = 1'b0;
      next_st.tg_kbd.vld = 1'b0;
      next_st.tx.vld = 1'b0;
      next_st.pc_tx.vld = 1'b0;
      next_st.sel.vld = 1'b0;
      next_st.dump.start = 1'b0;
      next_st.sx_ok = 1'b0;
      next_st.mem_we = 1'b0;
      next_st.edit_we = 1'b0;
      next_st.edit_drop = 1'b0;

      // register writes
      if (reg_wr_i) begin
         case (reg_addr_i)
            A_CHAN: next_st.chan = reg_wdata_i;
            A_MODE: next_st.mode = reg_wdata_i;
            A_DEV: next_st.dev = reg_wdata_i;
            A_PCM: begin
               // leaving direct must not keep a half-received pair armed
               next_st.pcm = reg_wdata_i[1:0];
               next_st.pend = 7'h00;
            end
            A_DSEL: next_st.dsel = reg_wdata_i;
            A_DUMP: begin
               // only kinds 01..12 start, never while busy
               if (reg_wdata_i[3:0] >= DUMP_MIN && reg_wdata_i[3:0] <= DUMP_MAX
                   && st.dst != MCP_D_BUSY
                   && (reg_wdata_i[3:0] != DUMP_1MULTI || st.cur_mem == MC_MULTI_LO)) begin
                  next_st.dkind = reg_wdata_i[3:0];
                  next_st.dst = MCP_D_BUSY;
                  next_st.dump.start = 1'b1;
                  next_st.dump.kind = reg_wdata_i[3:0];
                  // bank and number go with it
                  next_st.dump.bank = st.dsel[DS_BANK+:2];
                  next_st.dump.num = st.dsel[3:0];
                  next_st.dump.dev = st.dev[3:0];
               end
            end
            default: ;
         endcase
      end

      // register reads, data valid in the next cycle only
      if (reg_rd_i) begin
         case (reg_addr_i)
            A_CHAN: next_st.rdata = st.chan;
            A_MODE: next_st.rdata = st.mode;
            A_DEV: next_st.rdata = st.dev;
            A_PCM: next_st.rdata = {6'h00, st.pcm};
            A_DSEL: next_st.rdata = st.dsel;
            A_DUMP: next_st.rdata = {st.dkind, 2'h0, st.dst == MCP_D_DONE, st.dst == MCP_D_BUSY};
            A_MEM: next_st.rdata = {1'b0, st.cur_mem};
            default: next_st.rdata = 8'h00;
         endcase
      end

      // busy until the engine reports the end
      case (st.dst)
         MCP_D_IDLE: ;
         MCP_D_BUSY: if (dump_end_i) next_st.dst = MCP_D_DONE;
         MCP_D_DONE: ;
         default: next_st.dst = MCP_D_IDLE;
      endcase

      if (kbd_i.vld) begin
         next_st.tx = is_chan(kbd_i.stat) ? rechan(kbd_i, st.chan[3:0]) : kbd_i;
         // local off cuts the tone path only
         if (st.mode[M_LOCAL]) next_st.tg_kbd = next_st.tx;
      end

      // received non program messages to the tones
      if (acc && !is_pc && (!is_note || nf_pass)) next_st.tg_rx = rx_i;

      if (acc && is_pc && st.pcm != PC_OFF) begin
         next_st.pend = 7'h00;
         next_st.sel.part = rch;
         next_st.sel.mem = st.pend;
         if (rx_i.d1 < NUM_MULTI_LO) begin
            if (st.pend == 7'h00 || st.pend < MC_MULTI_LO) begin
               next_st.sel.vld = 1'b1;
               next_st.sel.multi = 1'b0;
               next_st.sel.num = rx_i.d1[5:0];
            end
         end else if (rx_i.d1 <= NUM_MULTI_HI) begin
            // multi select on the receive channel
            if ((st.mode[M_MULTI] || st.pend >= MC_MULTI_LO) && rch == st.chan[C_RX+:4]
                && (st.pend == 7'h00 || st.pend >= MC_MULTI_LO)) begin
               next_st.sel.vld = 1'b1;
               next_st.sel.multi = 1'b1;
               next_st.sel.num = {2'h0, rx_i.d1[3:0]};
            end
         end else if (rx_i.d1 >= MC_VOICE_LO && st.pcm == PC_DIRECT) begin
            // code armed for the next number
            // card multi code folds onto internal
            next_st.pend = (rx_i.d1 == MC_MI_CARD) ? MC_MI_INT : rx_i.d1;
         end
      end

      // second half of a direct pair wins; a selection arriving in that cycle is not sent
      if (st.txhold) begin
         next_st.pc_tx = '{vld: 1'b1, stat: {ST_PC, st.chan[3:0]}, d1: st.txnum, d2: 7'h00};
         next_st.txhold = 1'b0;
      end else if (sel_i.vld && st.pcm != PC_OFF) begin
         next_st.pc_tx = '{vld: 1'b1, stat: {ST_PC, st.chan[3:0]}, d1: tx_num, d2: 7'h00};
         // direct sends code only on a change
         if (st.pcm == PC_DIRECT && sel_i.mem != st.txlast) begin
            next_st.pc_tx.d1 = sel_i.mem;
            next_st.txhold = 1'b1;
            next_st.txnum = tx_num;
            next_st.txlast = sel_i.mem;
         end
      end
      if (sel_i.vld) next_st.cur_mem = sel_i.mem;

      if (sx_i.vld) begin
         next_st.sx_ok = (st.dev[DV_MODE+:2] == DV_ALL)
                         || (st.dev[DV_MODE+:2] == DV_NUM && sx_i.dev == st.dev[3:0]);
         next_st.mem_we = next_st.sx_ok && sx_i.bulk && !sx_i.single && !st.mode[M_PROT];
         next_st.edit_we = next_st.sx_ok && sx_i.single;
      end

      // edit buffer lost on memory change; a new single wins
      if (store_i) next_st.edit_full = 1'b0;
      if (st.edit_full && (mem_chg || next_st.sel.vld && st.pend != 7'h00)) begin
         next_st.edit_full = 1'b0;
         next_st.edit_drop = 1'b1;
      end
      if (next_st.edit_we) next_st.edit_full = 1'b1;
   end

   // state register
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st <= '0;
         st.chan <= RST_CHAN;
         st.mode <= RST_MODE;
         st.dev <= RST_DEV;
         st.pcm <= RST_PCM;
         st.dst <= MCP_D_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state flops
   assign reg_rdata_o = st.rdata;
   assign tg_rx_o = st.tg_rx;
   assign tg_kbd_o = st.tg_kbd;
   assign tx_o = st.tx;
   assign pc_tx_o = st.pc_tx;
   assign sel_o = st.sel;
   assign dump_o = st.dump;
   assign sx_ok_o = st.sx_ok;
   assign mem_we_o = st.mem_we;
   assign edit_we_o = st.edit_we;
   assign edit_drop_o = st.edit_drop;

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_local;
      kbd_i.vld && !st.mode[M_LOCAL] |=> !tg_kbd_o.vld;
   endproperty
   a_local: assert property (p_local) else $error("keyboard reached tones with local off");

   property p_txch;
      kbd_i.vld && is_chan(kbd_i.stat) |=> tx_o.vld && tx_o.stat[3:0] == $past(st.chan[3:0]);
   endproperty
   a_txch: assert property (p_txch) else $error("keyboard sent on wrong channel");

   property p_rxch;
      rx_i.vld && is_chan(rx_i.stat) && !st.mode[M_MULTI] && !st.mode[M_OMNI]
      && rx_i.stat[3:0] != st.chan[C_RX+:4] |=> !tg_rx_o.vld && !sel_o.vld;
   endproperty
   a_rxch: assert property (p_rxch) else $error("foreign channel accepted");

   property p_odd;
      acc && is_note && st.mode[M_NF+:2] == NF_ODD && !rx_i.d1[0] |=> !tg_rx_o.vld;
   endproperty
   a_odd: assert property (p_odd) else $error("even note passed odd filter");

   property p_devoff;
      sx_i.vld && st.dev[DV_MODE+:2] == DV_OFF |=> !sx_ok_o && !mem_we_o && !edit_we_o;
   endproperty
   a_devoff: assert property (p_devoff) else $error("sysex accepted while off");

   property p_prot;
      sx_i.vld && st.mode[M_PROT] |=> !mem_we_o;
   endproperty
   a_prot: assert property (p_prot) else $error("bulk written while protected");

   property p_pcoff;
      st.pcm == PC_OFF && !st.txhold |=> !pc_tx_o.vld && !sel_o.vld;
   endproperty
   a_pcoff: assert property (p_pcoff) else $error("program change while off");

   property p_normhi;
      acc && is_pc && st.pcm == PC_NORMAL && !st.mode[M_MULTI] && rx_i.d1 >= NUM_MULTI_LO |=> !sel_o.vld;
   endproperty
   a_normhi: assert property (p_normhi) else $error("high number selected in voice mode");

   property p_pair;
      pc_tx_o.vld && pc_tx_o.d1 >= MC_VOICE_LO |=> pc_tx_o.vld && pc_tx_o.d1 <= NUM_MULTI_HI;
   endproperty
   a_pair: assert property (p_pair) else $error("memory code not followed by number");

   property p_fold;
      sel_o.vld |-> sel_o.mem != MC_MI_CARD;
   endproperty
   a_fold: assert property (p_fold) else $error("card multi code not folded");

   property p_busy;
      dump_o.start |-> st.dst == MCP_D_BUSY ##1 (st.dst == MCP_D_BUSY || $past(dump_end_i));
   endproperty
   a_busy: assert property (p_busy) else $error("dump not shown busy");

   c_pair: cover property (pc_tx_o.vld && pc_tx_o.d1 >= MC_VOICE_LO ##1 pc_tx_o.vld);
   c_done: cover property (st.dst == MCP_D_BUSY ##1 st.dst == MCP_D_DONE);
   c_multi: cover property (sel_o.vld && sel_o.multi && sel_o.mem != 7'h00);
   c_drop: cover property (edit_drop_o);
endmodule

// ---- test/mcp_peer.sv ----
module mcp_peer
   import mcp_pkg::*;
#(
   parameter logic [3:0] PEER_DEV = 4'h3
)
(
   input  wire logic               clk_i,
   input  wire mcp_pkg::mcp_dump_t dump_i,
   output mcp_pkg::mcp_msg_t       rx_o,
   output logic                    dump_ok_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle line, nothing pending
   initial begin
      rx_o = '0;
   end

   // one message; fields flip once vld drops so nobody leans on stale data
   task automatic send(input logic [7:0] stat, input logic [6:0] d1);
      @(posedge clk_i);
      rx_o <= '{1'b1, stat, d1, 7'h00};
      @(posedge clk_i);
      rx_o <= '{1'b0, ~stat, ~d1, 7'h7F};
      #1;
   endtask

   task automatic send_pair(input logic [7:0] stat, input logic [6:0] code, input logic [6:0] num);
      send(stat, code);
      send(stat, num);
   endtask

   // dump kept only on equal device
   always_ff @(posedge clk_i) begin
      if (dump_i.start) begin
         dump_ok_o <= (dump_i.dev == PEER_DEV);
      end
   end
endmodule

// ---- test/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mcp_pkg::*;

   logic       clk_i;
   logic       sys_rst_i;
   logic [3:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic       reg_wr_i;
   logic       reg_rd_i;
   logic [7:0] reg_rdata_o;
   mcp_msg_t   rx_i;
   mcp_msg_t   kbd_i;
   mcp_sel_t   sel_i;
   mcp_sx_t    sx_i;
   logic       store_i;
   logic       dump_end_i;
   mcp_msg_t   tg_rx_o;
   mcp_msg_t   tg_kbd_o;
   mcp_msg_t   tx_o;
   mcp_msg_t   pc_tx_o;
   mcp_sel_t   sel_o;
   mcp_dump_t  dump_o;
   logic       sx_ok_o;
   logic       mem_we_o;
   logic       edit_we_o;
   logic       edit_drop_o;
   logic       dump_ok;
   int         failures;
   int         n_checks;

   mcp_filter dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_i(rx_i), .kbd_i(kbd_i),
      .sel_i(sel_i), .sx_i(sx_i), .store_i(store_i), .dump_end_i(dump_end_i), .tg_rx_o(tg_rx_o),
      .tg_kbd_o(tg_kbd_o), .tx_o(tx_o), .pc_tx_o(pc_tx_o), .sel_o(sel_o), .dump_o(dump_o), .sx_ok_o(sx_ok_o),
      .mem_we_o(mem_we_o), .edit_we_o(edit_we_o), .edit_drop_o(edit_drop_o));

   mcp_peer #(.PEER_DEV(4'h3)) peer_u (.clk_i(clk_i), .dump_i(dump_o), .rx_o(rx_i), .dump_ok_o(dump_ok));

   // free-running 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   // strobes last one cycle; results sampled just after the taking edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk(reg_rdata_o, e);
   endtask

   task automatic kb(input logic [7:0] st, input logic [6:0] d1);
      @(posedge clk_i);
      kbd_i <= '{1'b1, st, d1, 7'h40};
      @(posedge clk_i);
      kbd_i.vld <= 1'b0;
      #1;
   endtask

   task automatic sx(input logic [3:0] dv, input logic bk, input logic sg);
      @(posedge clk_i);
      sx_i <= '{1'b1, dv, bk, sg};
      @(posedge clk_i);
      sx_i.vld <= 1'b0;
      #1;
   endtask

   task automatic sl(input logic m, input logic [6:0] mem, input logic [5:0] num);
      @(posedge clk_i);
      sel_i <= '{1'b1, m, 4'h0, mem, num};
      @(posedge clk_i);
      sel_i.vld <= 1'b0;
      #1;
   endtask

   // hang guard, far beyond the roughly 130 cycles used
   initial begin
      #100000;
      failures++;
      end_of_test();
   end

   initial begin
      failures = 0;
      n_checks = 0;
      {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} = '0;
      {kbd_i, sel_i, sx_i, store_i, dump_end_i} = '0;
      sys_rst_i = 1'b1;
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      // reset values, unmapped index
      rd(A_CHAN, RST_CHAN);
      rd(A_MODE, RST_MODE);
      rd(A_DEV, RST_DEV);
      rd(A_PCM, 8'h01);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      // tx channel 6, rx channel 4, local on, odd filter
      wr(A_CHAN, 8'h35);
      wr(A_MODE, 8'h06);
      kb(8'h90, 7'h3C);
      chk(tx_o.stat, 8'h95);
      chk(tg_kbd_o.vld, 1'b1);
      peer_u.send(8'h93, 7'h3D);
      chk(tg_rx_o.vld, 1'b1);
      chk(tg_rx_o.d1, 8'h3D);
      peer_u.send(8'h93, 7'h3C);
      chk(tg_rx_o.vld, 1'b0);
      peer_u.send(8'h94, 7'h3D);
      chk(tg_rx_o.vld, 1'b0);
      // omni, even filter, local off
      wr(A_MODE, 8'h09);
      peer_u.send(8'h94, 7'h3C);
      chk(tg_rx_o.vld, 1'b1);
      peer_u.send(8'h93, 7'h3D);
      chk(tg_rx_o.vld, 1'b0);
      kb(8'h90, 7'h3C);
      chk(tx_o.vld, 1'b1);
      chk(tg_kbd_o.vld, 1'b0);
      // device number, off, all
      sx(4'h0, 1'b1, 1'b0);
      chk(sx_ok_o, 1'b1);
      chk(mem_we_o, 1'b1);
      sx(4'h1, 1'b1, 1'b0);
      chk(sx_ok_o, 1'b0);
      wr(A_DEV, 8'h00);
      sx(4'h0, 1'b1, 1'b0);
      chk(sx_ok_o, 1'b0);
      wr(A_DEV, 8'h23);
      sx(4'h9, 1'b1, 1'b0);
      chk(sx_ok_o, 1'b1);
      sx(4'h9, 1'b0, 1'b1);
      chk(edit_we_o, 1'b1);
      chk(mem_we_o, 1'b0);
      wr(A_MODE, 8'h12);
      sx(4'h9, 1'b1, 1'b0);
      chk(mem_we_o, 1'b0);
      // normal handling, voice mode
      sl(1'b0, 7'h7A, 6'd3);
      chk(pc_tx_o.stat, 8'hC5);
      chk(pc_tx_o.d1, 8'd3);
      chk(edit_drop_o, 1'b1);
      sl(1'b1, 7'h7D, 6'd3);
      chk(pc_tx_o.d1, 8'd67);
      peer_u.send(8'hC3, 7'd5);
      chk(sel_o.vld, 1'b1);
      chk(sel_o.num, 8'd5);
      peer_u.send(8'hC3, 7'd64);
      chk(sel_o.vld, 1'b0);
      // normal handling, multi mode
      wr(A_MODE, 8'h22);
      peer_u.send(8'hC3, 7'd70);
      chk(sel_o.multi, 1'b1);
      chk(sel_o.num, 8'd6);
      peer_u.send(8'hC7, 7'd70);
      chk(sel_o.vld, 1'b0);
      peer_u.send(8'hC7, 7'd10);
      chk(sel_o.part, 8'h7);
      peer_u.send(8'hC3, 7'd80);
      chk(sel_o.vld, 1'b0);
      // handling off
      wr(A_PCM, 8'h00);
      peer_u.send(8'hC3, 7'd5);
      chk(sel_o.vld, 1'b0);
      sl(1'b0, 7'h7A, 6'd1);
      chk(pc_tx_o.vld, 1'b0);
      // direct: new memory code leads the number
      wr(A_PCM, 8'h02);
      sl(1'b0, 7'h7B, 6'd2);
      chk(pc_tx_o.d1, 8'd123);
      @(posedge clk_i);
      #1;
      chk(pc_tx_o.d1, 8'd2);
      sl(1'b0, 7'h7B, 6'd4);
      chk(pc_tx_o.d1, 8'd4);
      sl(1'b1, 7'h7E, 6'd3);
      chk(pc_tx_o.d1, 8'd126);
      @(posedge clk_i);
      #1;
      chk(pc_tx_o.d1, 8'd67);
      peer_u.send_pair(8'hC3, 7'd120, 7'd5);
      chk(sel_o.mem, 8'd119);
      chk(sel_o.num, 8'd5);
      peer_u.send_pair(8'hC3, 7'd127, 7'd66);
      chk(sel_o.mem, 8'd127);
      chk(sel_o.multi, 1'b1);
      // dumps
      wr(A_DSEL, 8'h25);
      rd(A_DSEL, 8'h25);
      wr(A_DUMP, 8'h07);
      chk(dump_o.start, 1'b1);
      chk(dump_o.kind, 8'h7);
      chk({dump_o.bank, dump_o.num}, 8'h25);
      chk(dump_o.dev, 8'h3);
      rd(A_DUMP, 8'h71);
      chk(dump_ok, 1'b1);
      wr(A_DUMP, 8'h0C);
      chk(dump_o.start, 1'b0);
      @(posedge clk_i);
      dump_end_i <= 1'b1;
      @(posedge clk_i);
      dump_end_i <= 1'b0;
      rd(A_DUMP, 8'h72);
      wr(A_DUMP, 8'h0D);
      chk(dump_o.start, 1'b0);
      wr(A_DUMP, 8'h08);
      chk(dump_o.start, 1'b0);
      sl(1'b1, 7'h7D, 6'd0);
      wr(A_DUMP, 8'h08);
      chk(dump_o.start, 1'b1);
      rd(A_MEM, 8'h7D);
      // a stored edit buffer is not lost on the next memory change
      sx(4'h9, 1'b0, 1'b1);
      chk(edit_we_o, 1'b1);
      @(posedge clk_i);
      store_i <= 1'b1;
      @(posedge clk_i);
      store_i <= 1'b0;
      sl(1'b1, 7'h7E, 6'd1);
      chk(edit_drop_o, 1'b0);
      rd(A_MEM, 8'h7E);
      end_of_test();
   end
endmodule
